// File: awt_defs.vh
// Constants for the waveform timer core: register offsets, field positions,
// reset values, mode codes and source selections.
// Assumes inclusion by bare name from the design file.
`ifndef AWT_DEFS_VH
`define AWT_DEFS_VH

// Register offsets on the 5-bit register port.
`define AWT_OFF_CTRL_A 5'h00
`define AWT_OFF_STATUS 5'h01
`define AWT_OFF_CMD 5'h02
`define AWT_OFF_A_SET 5'h03
`define AWT_OFF_A_CLR 5'h04
`define AWT_OFF_B_SET 5'h05
`define AWT_OFF_B_CLR 5'h06
`define AWT_OFF_DLY_CTRL 5'h07
`define AWT_OFF_DLY_VAL 5'h08
`define AWT_OFF_CAPT_A 5'h09
`define AWT_OFF_CAPT_B 5'h0a
`define AWT_OFF_CTRL_B 5'h0b
`define AWT_OFF_IRQ_EN 5'h0c
`define AWT_OFF_IRQ_FLAG 5'h0d

// Control register A fields.
`define AWT_A_ENABLE 0
`define AWT_A_SRC_LO 2
`define AWT_A_CDIV_LO 4
`define AWT_A_WAVE_LO 6
`define AWT_A_SDIV_LO 8
`define AWT_CTRL_A_RST 16'h0000
`define AWT_CTRL_A_MASK 16'h03fd

// Command strobe bits.
`define AWT_CMD_UPD_EOC 0
`define AWT_CMD_UPD_NOW 1
`define AWT_CMD_RESTART 2
`define AWT_CMD_CAPT_A 3
`define AWT_CMD_CAPT_B 4
`define AWT_CMD_STOP_EOC 5

// Delay control fields: divider select and delayed event enable.
`define AWT_DLY_DIV_LO 0
`define AWT_DLY_EN 2

// Source selections and waveform shapes.
`define AWT_SRC_RC 2'h0
`define AWT_SRC_EXT 2'h1
`define AWT_SRC_SYS 2'h2
`define AWT_WAVE_ONE 2'h0
`define AWT_WAVE_TWO 2'h1
`define AWT_WAVE_FOUR 2'h2
`define AWT_WAVE_DUAL 2'h3

`define AWT_CMP_RST 12'h000
`endif

// File: awt_src_model.sv
// Source pins feeding the core: a free-running RC clock and an external clock.
// Assumes mclk from the bench; both pins change just after its rising edge.
module awt_src_model (
  input wire mclk,
  output logic rc_osc = 1'b0,
  output logic ext_clk = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt = 4'h0;
  // Periods of 8 and 12 mclk cycles keep the expected counts exact.
  always @(posedge mclk) begin
    cnt <= (cnt == 4'hb) ? 4'h0 : cnt + 4'h1;
    if (cnt[1:0] == 2'h3) rc_osc <= ~rc_osc;
    if (cnt == 4'h5 || cnt == 4'hb) ext_clk <= ~ext_clk;
  end
endmodule // awt_src_model

// File: awt_timer_core.v
// Twelve-bit waveform timer with a register port, command handshakes,
// three prescalers and four waveform shapes driving two power-stage outputs.
// Assumes one clock mclk; the RC and external clock sources arrive as pins.
//
// Added by the designer: the strobed register port and the register offsets.
`include "awt_defs.vh"

// Summary of operation
// - Enable cleared stops core at transfer.
// - Stop strobe disables at cycle end.
// - Control A fields locked while enabled.
// - Enable change accepted only when ready.
// - Commands transfer only enabled and idle.
// - Command bits self-clear once executed.
// - Update at cycle end or immediately.
// - Restart returns counter to cycle start.
// - Software captures counter into A or B.
// - Buffered writes need ready while enabled; copied on update.
// - Static registers ignore writes while enabled.
// - Status, capture, flag registers need no handshake.
// - Three sources; counter division is product.
// - Separate faster synchroniser clock for transfers.
// - Independent delay prescaler for delayed event.
// - Four states: dead A, on A, dead B, on B.
// - Waveform field picks one of four shapes.
// - One ramp counts to B-clear, restarts zero.
// - Source select: RC oscillator, external, system.
// - Two ramp: to A-clear, then B-clear.
// - Four ramp: one ramp to each compare.
// - Dual slope: down from B-clear and up.
module awt_timer_core (
  input wire mclk,
  input wire sys_rst,
  input wire internal_rc_osc,
  input wire ext_clk_in,
  input wire [4:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  output reg wave_out_a,
  output reg wave_out_b,
  output reg [3:0] cycle_state,
  output reg delayed_event
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // A divider by 1, 2, 4 or 8 fires when the low sel bits of its count are all set.
  function div_hit;
    input [2:0] cnt;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: div_hit = 1'b1;
        2'h1: div_hit = cnt[0];
        2'h2: div_hit = &cnt[1:0];
        default: div_hit = &cnt[2:0];
      endcase
    end
  endfunction

  localparam ST_DEAD_A = 4'h1;
  localparam ST_ON_A = 4'h2;
  localparam ST_DEAD_B = 4'h4;
  localparam ST_ON_B = 4'h8;

  // ----------------------------------------------------------------------
  // Software-side registers
  // ----------------------------------------------------------------------
  reg [15:0] control_reg_a;
  reg [15:0] control_reg_b;
  reg [11:0] a_set_point;
  reg [11:0] a_clear_point;
  reg [11:0] b_set_point;
  reg [11:0] b_clear_point;
  reg [2:0] delay_control_reg;
  reg [11:0] delay_value_reg;
  reg [7:0] irq_enable_reg;
  reg irq_flag_cycle;
  reg [5:0] cmd_pend;
  reg en_pend;
  reg buf_pend;
  reg [11:0] capture_reg_a;
  reg [11:0] capture_reg_b;

  // ----------------------------------------------------------------------
  // Core-side state
  // ----------------------------------------------------------------------
  reg core_en;
  reg en_ack;
  reg cmd_busy;
  reg upd_eoc;
  reg stop_eoc;
  reg [5:0] cmd_clr;
  reg stop_done;
  reg [11:0] cnt;
  reg count_down;
  reg [3:0] state;
  reg [11:0] c_aset;
  reg [11:0] c_aclr;
  reg [11:0] c_bset;
  reg [11:0] c_bclr;
  reg [2:0] c_dly;
  reg [11:0] c_delay_value_reg;
  reg [11:0] dly_cnt;
  reg dly_run;
  reg eoc;

  wire enable_ready_flag = ~en_pend;
  wire command_ready_flag = ~(|cmd_pend) & ~buf_pend & ~cmd_busy;
  wire enabled = control_reg_a[`AWT_A_ENABLE] | core_en;
  wire [1:0] source_clock_sel = control_reg_a[`AWT_A_SRC_LO+1:`AWT_A_SRC_LO];
  wire [1:0] counter_clock_divider = control_reg_a[`AWT_A_CDIV_LO+1:`AWT_A_CDIV_LO];
  wire [1:0] waveform_shape_sel = control_reg_a[`AWT_A_WAVE_LO+1:`AWT_A_WAVE_LO];
  wire [1:0] sync_clock_divider = control_reg_a[`AWT_A_SDIV_LO+1:`AWT_A_SDIV_LO];

  // ----------------------------------------------------------------------
  // Clock sources and prescalers
  // ----------------------------------------------------------------------
  reg [2:0] rc_sync;
  reg [2:0] ext_sync;
  reg [2:0] sync_div;
  reg [2:0] cnt_div;
  reg [2:0] dly_div;
  wire rc_rise = rc_sync[1] & ~rc_sync[2];
  wire ext_rise = ext_sync[1] & ~ext_sync[2];
  reg src_tick;

  always @* begin
    case (source_clock_sel)
      `AWT_SRC_RC: src_tick = rc_rise;
      `AWT_SRC_EXT: src_tick = ext_rise;
      `AWT_SRC_SYS: src_tick = 1'b1;
      default: src_tick = 1'b0;
    endcase
  end

  // Transfers run on the synchroniser tick, ahead of the slower counter tick.
  wire sync_tick = src_tick & div_hit(sync_div, sync_clock_divider);
  wire cnt_tick = sync_tick & div_hit(cnt_div, counter_clock_divider);
  wire dly_tick = sync_tick & div_hit(dly_div, c_dly[1:0]);

  always @(posedge mclk) begin
    if (sys_rst) begin
      rc_sync <= 3'h0;
      ext_sync <= 3'h0;
      sync_div <= 3'h0;
      cnt_div <= 3'h0;
      dly_div <= 3'h0;
    end else begin
      rc_sync <= {rc_sync[1:0], internal_rc_osc};
      ext_sync <= {ext_sync[1:0], ext_clk_in};
      if (src_tick)
        sync_div <= sync_div + 3'h1;
      if (sync_tick)
        cnt_div <= cnt_div + 3'h1;
      if (sync_tick)
        dly_div <= dly_div + 3'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------
  wire wr_ctrl_a = reg_wr & (reg_addr == `AWT_OFF_CTRL_A);
  wire en_bit = reg_wdata[`AWT_A_ENABLE];
  // Buffered registers are open while disabled, or while enabled and idle.
  wire buf_open = ~enabled | command_ready_flag;
  wire en_xfer_done = en_ack & sync_tick;

  always @(posedge mclk) begin
    if (sys_rst) begin
      control_reg_a <= `AWT_CTRL_A_RST;
      control_reg_b <= 16'h0000;
      a_set_point <= `AWT_CMP_RST;
      a_clear_point <= `AWT_CMP_RST;
      b_set_point <= `AWT_CMP_RST;
      b_clear_point <= `AWT_CMP_RST;
      delay_control_reg <= 3'h0;
      delay_value_reg <= 12'h000;
      irq_enable_reg <= 8'h00;
      irq_flag_cycle <= 1'b0;
      cmd_pend <= 6'h00;
      en_pend <= 1'b0;
      buf_pend <= 1'b0;
    end else begin
      if (stop_done)
        control_reg_a[`AWT_A_ENABLE] <= 1'b0;
      if (wr_ctrl_a && enable_ready_flag) begin
        if (!enabled)
          control_reg_a <= reg_wdata & `AWT_CTRL_A_MASK;
        else
          control_reg_a[`AWT_A_ENABLE] <= en_bit;
        if (en_bit != control_reg_a[`AWT_A_ENABLE])
          en_pend <= 1'b1;
      end else if (en_xfer_done) begin
        en_pend <= 1'b0;
      end
      if (reg_wr && !enabled && reg_addr == `AWT_OFF_CTRL_B)
        control_reg_b <= reg_wdata;
      if (reg_wr && reg_addr == `AWT_OFF_IRQ_EN)
        irq_enable_reg <= reg_wdata[7:0];
      // A cycle end in the same cycle as the clearing write wins.
      if (core_en && cnt_tick && eoc)
        irq_flag_cycle <= 1'b1;
      else if (reg_wr && reg_addr == `AWT_OFF_IRQ_FLAG && reg_wdata[0])
        irq_flag_cycle <= 1'b0;
      if (reg_wr && buf_open) begin
        case (reg_addr)
          `AWT_OFF_A_SET: a_set_point <= reg_wdata[11:0];
          `AWT_OFF_A_CLR: a_clear_point <= reg_wdata[11:0];
          `AWT_OFF_B_SET: b_set_point <= reg_wdata[11:0];
          `AWT_OFF_B_CLR: b_clear_point <= reg_wdata[11:0];
          `AWT_OFF_DLY_CTRL: delay_control_reg <= reg_wdata[2:0];
          `AWT_OFF_DLY_VAL: delay_value_reg <= reg_wdata[11:0];
          default: ;
        endcase
      end
      if (reg_wr && enabled && command_ready_flag && reg_addr >= `AWT_OFF_A_SET &&
          reg_addr <= `AWT_OFF_DLY_VAL)
        buf_pend <= 1'b1;
      else if (sync_tick)
        buf_pend <= 1'b0;
      if (reg_wr && reg_addr == `AWT_OFF_CMD && command_ready_flag)
        cmd_pend <= reg_wdata[5:0];
      else
        cmd_pend <= cmd_pend & ~cmd_clr;
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `AWT_OFF_CTRL_A: reg_rdata <= control_reg_a;
        `AWT_OFF_STATUS: reg_rdata <= {14'h0000, command_ready_flag, enable_ready_flag};
        `AWT_OFF_CMD: reg_rdata <= {10'h000, cmd_pend};
        `AWT_OFF_A_SET: reg_rdata <= {4'h0, a_set_point};
        `AWT_OFF_A_CLR: reg_rdata <= {4'h0, a_clear_point};
        `AWT_OFF_B_SET: reg_rdata <= {4'h0, b_set_point};
        `AWT_OFF_B_CLR: reg_rdata <= {4'h0, b_clear_point};
        `AWT_OFF_DLY_CTRL: reg_rdata <= {13'h0000, delay_control_reg};
        `AWT_OFF_DLY_VAL: reg_rdata <= {4'h0, delay_value_reg};
        `AWT_OFF_CAPT_A: reg_rdata <= {4'h0, capture_reg_a};
        `AWT_OFF_CAPT_B: reg_rdata <= {4'h0, capture_reg_b};
        `AWT_OFF_CTRL_B: reg_rdata <= control_reg_b;
        `AWT_OFF_IRQ_EN: reg_rdata <= {8'h00, irq_enable_reg};
        `AWT_OFF_IRQ_FLAG: reg_rdata <= {15'h0000, irq_flag_cycle};
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Counter sequencing per waveform shape
  // ----------------------------------------------------------------------
  reg [11:0] next_cnt;
  reg [3:0] next_state;
  reg next_down;
  reg set_a, clr_a, set_b, clr_b;
  reg [11:0] top;

  always @* begin
    next_cnt = cnt + 12'h001;
    next_state = state;
    next_down = count_down;
    eoc = 1'b0;
    set_a = 1'b0;
    clr_a = 1'b0;
    set_b = 1'b0;
    clr_b = 1'b0;
    top = c_bclr;
    case (waveform_shape_sel)
      `AWT_WAVE_ONE: begin
        set_a = (cnt == c_aset);
        clr_a = (cnt == c_aclr);
        set_b = (cnt == c_bset);
        clr_b = (cnt == c_bclr);
        if (cnt == c_bclr) begin
          next_cnt = 12'h000;
          eoc = 1'b1;
        end
        if (clr_b || cnt < c_aset)
          next_state = ST_DEAD_A;
        else if (cnt < c_aclr)
          next_state = ST_ON_A;
        else if (cnt < c_bset)
          next_state = ST_DEAD_B;
        else
          next_state = ST_ON_B;
      end
      `AWT_WAVE_TWO: begin
        top = state[0] | state[1] ? c_aclr : c_bclr;
        if (state[0] | state[1]) begin
          set_a = (cnt == c_aset);
          clr_a = (cnt == c_aclr);
          next_state = set_a ? ST_ON_A : state;
        end else begin
          set_b = (cnt == c_bset);
          clr_b = (cnt == c_bclr);
          next_state = set_b ? ST_ON_B : state;
        end
        if (cnt == top) begin
          next_cnt = 12'h000;
          eoc = state[2] | state[3];
          next_state = eoc ? ST_DEAD_A : ST_DEAD_B;
        end
      end
      `AWT_WAVE_FOUR: begin
        case (state)
          ST_DEAD_A: top = c_aset;
          ST_ON_A: top = c_aclr;
          ST_DEAD_B: top = c_bset;
          default: top = c_bclr;
        endcase
        if (cnt == top) begin
          next_cnt = 12'h000;
          set_a = state[0];
          clr_a = state[1];
          set_b = state[2];
          clr_b = state[3];
          eoc = state[3];
          next_state = state[3] ? ST_DEAD_A : {state[2:0], 1'b0};
        end
      end
      default: begin
        // Zero and top are each held for two ticks, so a cycle is twice top plus two.
        if (count_down) begin
          next_cnt = cnt - 12'h001;
          clr_a = (cnt == c_aset);
          set_b = (cnt == c_bset);
          if (cnt == 12'h000) begin
            next_cnt = 12'h000;
            next_down = 1'b0;
          end
        end else begin
          set_a = (cnt == c_aset);
          clr_b = (cnt == c_bset);
          if (cnt == c_bclr) begin
            next_cnt = cnt;
            next_down = 1'b1;
            eoc = 1'b1;
          end
        end
        if (set_a)
          next_state = ST_ON_A;
        else if (clr_a)
          next_state = ST_DEAD_B;
        else if (set_b)
          next_state = ST_ON_B;
        else if (clr_b)
          next_state = ST_DEAD_A;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Core: enable transfer, commands, counter and outputs
  // ----------------------------------------------------------------------
  wire cmd_take = sync_tick & core_en & (|cmd_pend) & ~cmd_busy;
  wire restart_now = cmd_take & cmd_pend[`AWT_CMD_RESTART];
  wire cycle_end = core_en & cnt_tick & eoc;
  wire [11:0] start_cnt = (waveform_shape_sel == `AWT_WAVE_DUAL) ? c_bclr : 12'h000;

  always @(posedge mclk) begin
    if (sys_rst) begin
      core_en <= 1'b0;
      en_ack <= 1'b0;
      cmd_busy <= 1'b0;
      upd_eoc <= 1'b0;
      stop_eoc <= 1'b0;
      cmd_clr <= 6'h00;
      stop_done <= 1'b0;
      cnt <= 12'h000;
      count_down <= 1'b0;
      state <= ST_DEAD_A;
      c_aset <= `AWT_CMP_RST;
      c_aclr <= `AWT_CMP_RST;
      c_bset <= `AWT_CMP_RST;
      c_bclr <= `AWT_CMP_RST;
      c_dly <= 3'h0;
      c_delay_value_reg <= 12'h000;
      capture_reg_a <= 12'h000;
      capture_reg_b <= 12'h000;
      wave_out_a <= 1'b0;
      wave_out_b <= 1'b0;
      cycle_state <= ST_DEAD_A;
    end else begin
      cmd_clr <= 6'h00;
      stop_done <= 1'b0;
      if (en_xfer_done)
        en_ack <= 1'b0;
      if (sync_tick && en_pend && !en_ack) begin
        en_ack <= 1'b1;
        core_en <= control_reg_a[`AWT_A_ENABLE];
        if (control_reg_a[`AWT_A_ENABLE]) begin
          c_aset <= a_set_point;
          c_aclr <= a_clear_point;
          c_bset <= b_set_point;
          c_bclr <= b_clear_point;
          c_dly <= delay_control_reg;
          c_delay_value_reg <= delay_value_reg;
          cnt <= (waveform_shape_sel == `AWT_WAVE_DUAL) ? b_clear_point : 12'h000;
          count_down <= 1'b1;
          state <= ST_DEAD_A;
        end else begin
          wave_out_a <= 1'b0;
          wave_out_b <= 1'b0;
          upd_eoc <= 1'b0;
          stop_eoc <= 1'b0;
          cmd_busy <= 1'b0;
          cmd_clr <= cmd_pend;
        end
      end else if (core_en) begin
        if (cmd_take) begin
          cmd_busy <= cmd_pend[`AWT_CMD_UPD_EOC] | cmd_pend[`AWT_CMD_STOP_EOC];
          upd_eoc <= cmd_pend[`AWT_CMD_UPD_EOC];
          stop_eoc <= cmd_pend[`AWT_CMD_STOP_EOC];
          cmd_clr <= cmd_pend & 6'h1e;
          if (cmd_pend[`AWT_CMD_CAPT_A])
            capture_reg_a <= cnt;
          if (cmd_pend[`AWT_CMD_CAPT_B])
            capture_reg_b <= cnt;
        end
        if ((cmd_take && cmd_pend[`AWT_CMD_UPD_NOW]) || (cycle_end && upd_eoc)) begin
          c_aset <= a_set_point;
          c_aclr <= a_clear_point;
          c_bset <= b_set_point;
          c_bclr <= b_clear_point;
          c_dly <= delay_control_reg;
          c_delay_value_reg <= delay_value_reg;
        end
        if (cycle_end && cmd_busy) begin
          cmd_busy <= 1'b0;
          upd_eoc <= 1'b0;
          stop_eoc <= 1'b0;
          cmd_clr <= {stop_eoc, 4'h0, upd_eoc};
        end
        if (cycle_end && stop_eoc) begin
          core_en <= 1'b0;
          stop_done <= 1'b1;
          wave_out_a <= 1'b0;
          wave_out_b <= 1'b0;
        end else if (restart_now) begin
          cnt <= start_cnt;
          count_down <= 1'b1;
          state <= ST_DEAD_A;
        end else if (cnt_tick) begin
          cnt <= next_cnt;
          count_down <= next_down;
          state <= next_state;
          if (set_a)
            wave_out_a <= 1'b1;
          else if (clr_a)
            wave_out_a <= 1'b0;
          if (set_b)
            wave_out_b <= 1'b1;
          else if (clr_b)
            wave_out_b <= 1'b0;
        end
      end
      cycle_state <= state;
    end
  end

  // ----------------------------------------------------------------------
  // Delayed event output
  // ----------------------------------------------------------------------
  // The delay counter restarts at every cycle end and fires at most once per cycle.
  always @(posedge mclk) begin
    if (sys_rst) begin
      dly_cnt <= 12'h000;
      dly_run <= 1'b0;
      delayed_event <= 1'b0;
    end else begin
      delayed_event <= 1'b0;
      if (!core_en || !c_dly[`AWT_DLY_EN]) begin
        dly_run <= 1'b0;
      end else if (cycle_end) begin
        dly_cnt <= 12'h000;
        dly_run <= 1'b1;
      end else if (dly_run && dly_tick) begin
        if (dly_cnt == c_delay_value_reg) begin
          dly_run <= 1'b0;
          delayed_event <= 1'b1;
        end else begin
          dly_cnt <= dly_cnt + 12'h001;
        end
      end
    end
  end

endmodule // awt_timer_core

// File: awt_timer_core_monitor.sv
// Checker for the waveform timer core, watching its top-level ports only.
// Assumes one clock mclk and a synchronous active-high sys_rst.
module awt_mon (
  input wire mclk,
  input wire sys_rst,
  input wire [4:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  input wire wave_out_a,
  input wire wave_out_b,
  input wire [3:0] cycle_state,
  input wire delayed_event
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Last enable value written, so that only a real change of enable is checked.
  logic last_en;
  always @(posedge mclk) begin
    if (sys_rst) last_en <= 1'b0;
    else if (reg_wr && reg_addr == 5'h00) last_en <= reg_wdata[0];
  end
  // ----
  // Assertions
  // ----
  state_onehot_a: assert property ($onehot(cycle_state))
    else $error("cycle state is not one-hot");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  unmapped_zero_a: assert property (reg_rd && reg_addr > 5'h0d |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  narrow_value_a: assert property (reg_rd &&
    (reg_addr inside {[5'h03:5'h06], 5'h09, 5'h0a}) |=> reg_rdata[15:12] == 4'h0)
    else $error("twelve-bit value has upper bits set");
  stop_now_a: assert property (reg_wr && reg_addr == 5'h00 && !reg_wdata[0]
    |-> ##[1:40] (!wave_out_a && !wave_out_b) [*8])
    else $error("outputs not stopped after disable");
  pulse_one_a: assert property (delayed_event |=> !delayed_event)
    else $error("delayed event longer than one cycle");
  enable_ready_flag_drop_a: assert property (reg_wr && reg_addr == 5'h00 && reg_wdata[0] && !last_en
    ##[1:2] reg_rd && reg_addr == 5'h01 |=> !reg_rdata[0])
    else $error("enable ready high during transfer");
  command_ready_flag_drop_a: assert property (reg_wr && reg_addr == 5'h02
    ##[1:2] reg_rd && reg_addr == 5'h01 |=> !reg_rdata[1])
    else $error("command ready high during transfer");
  cover property (reg_wr && reg_addr == 5'h02);
  cover property (delayed_event);
  cover property (wave_out_a ##[1:40] wave_out_b);
endmodule // awt_mon

bind awt_timer_core awt_mon awt_mon_inst (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .wave_out_a(wave_out_a), .wave_out_b(wave_out_b), .cycle_state(cycle_state),
  .delayed_event(delayed_event));

// File: awt_timer_core_tb_top.sv
// Self-checking bench for the waveform timer core with its source-pin model.
// Assumes the core and the checker are compiled first.
module awt_timer_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic sys_rst, rc_osc, ext_clk, reg_wr, reg_rd, wave_out_a, wave_out_b, delayed_event;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [3:0] cycle_state;
  int num_errors, check_count;
  awt_timer_core awt_timer_core_inst (.mclk(mclk), .sys_rst(sys_rst), .internal_rc_osc(rc_osc),
    .ext_clk_in(ext_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .wave_out_a(wave_out_a), .wave_out_b(wave_out_b),
    .cycle_state(cycle_state), .delayed_event(delayed_event));
  awt_src_model awt_src_model_inst (.mclk(mclk), .rc_osc(rc_osc), .ext_clk(ext_clk));
  always #2.5 mclk = ~mclk;
  // ----
  // Bus and check helpers
  // ----
  task end_sim;
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task tmo;
    num_errors++;
    end_sim;
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    // A free edge after each write keeps two writes from touching the strobe in one step.
    @(posedge mclk);
  endtask
  task rd(input logic [4:0] a, output logic [15:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    v = reg_rdata;
  endtask
  task wrdy(input int b);
    logic [15:0] v;
    int i;
    for (i = 0; i < 200; i++) begin
      rd(5'h01, v);
      if (v[b] === 1'b1) break;
    end
    if (i == 200) tmo;
  endtask
  // Cycles between two successive rises of wave_out_b, the first one discarded.
  task period(output int n);
    logic p;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        p = wave_out_b;
        @(posedge mclk);
        n++;
        // A counter that overtakes a lowered top wraps through the full 12-bit range.
        if (n > 5000) tmo;
      end while (!(p === 1'b0 && wave_out_b === 1'b1));
    end
  endtask
  task en(input logic [15:0] cfg);
    logic [15:0] v;
    wr(5'h00, cfg);
    wrdy(0);
    wr(5'h00, cfg | 16'h0001);
    rd(5'h01, v);
    chk(v & 16'h0001, 16'h0000);
    wrdy(0);
  endtask
  task off;
    wr(5'h00, 16'h0000);
    wrdy(0);
    chk({wave_out_a, wave_out_b}, 16'h0000);
  endtask
  // ----
  // Scenarios
  // ----
  task t_reset;
    logic [15:0] v;
    rd(5'h00, v);
    chk(v, 16'h0000);
    rd(5'h1f, v);
    chk(v, 16'h0000);
    rd(5'h09, v);
    chk(v, 16'h0000);
    chk({12'h000, cycle_state}, 16'h0001);
  endtask
  task t_modes;
    int n, e;
    wr(5'h03, 16'h0002);
    wr(5'h04, 16'h0004);
    wr(5'h05, 16'h0006);
    wr(5'h06, 16'h0009);
    for (int i = 0; i < 4; i++) begin
      e = (i == 0) ? 10 : (i == 1) ? 5 + 10 : (i == 2) ? 3 + 5 + 7 + 10 : 2 * 10;
      en({8'h00, i[1:0], 6'h08});
      period(n);
      chk(n[15:0], e[15:0]);
      off;
    end
  endtask
  task t_div;
    logic [15:0] v;
    int n;
    wr(5'h0b, 16'h00a5);
    en(16'h0118);
    period(n);
    chk(n[15:0], 16'h0028);
    wr(5'h00, 16'h0009);
    wr(5'h0b, 16'h005a);
    rd(5'h00, v);
    chk(v, 16'h0119);
    rd(5'h0b, v);
    chk(v, 16'h00a5);
    off;
  endtask
  task t_src;
    int n;
    wr(5'h07, 16'h0004);
    wr(5'h08, 16'h0003);
    for (int s = 0; s < 2; s++) begin
      en(s ? 16'h0004 : 16'h0000);
      period(n);
      chk(n[15:0], s ? 16'h0078 : 16'h0050);
      for (n = 0; n < 200 && delayed_event !== 1'b1; n++) @(posedge mclk);
      chk({15'h0, delayed_event}, 16'h0001);
      off;
    end
  endtask
  task t_cmd;
    logic [15:0] v;
    int n;
    en(16'h0008);
    for (int c = 3; c < 5; c++) begin
      wr(5'h02, 16'h0001 << c);
      wrdy(1);
      rd(5'h02, v);
      chk(v, 16'h0000);
      rd(5'(c + 6), v);
      chk({15'h0, v <= 16'h0009}, 16'h0001);
    end
    wr(5'h06, 16'h0013);
    wrdy(1);
    period(n);
    chk(n[15:0], 16'h000a);
    wr(5'h02, 16'h0001);
    wrdy(1);
    period(n);
    chk(n[15:0], 16'h0014);
    wr(5'h06, 16'h0009);
    wrdy(1);
    wr(5'h02, 16'h0002);
    wrdy(1);
    period(n);
    chk(n[15:0], 16'h000a);
    wr(5'h02, 16'h0004);
    wrdy(1);
    rd(5'h02, v);
    chk(v, 16'h0000);
    for (n = 0; n < 100 && wave_out_a !== 1'b1; n++) @(posedge mclk);
    wr(5'h02, 16'h0020);
    rd(5'h00, v);
    chk(v & 16'h0001, 16'h0001);
    for (n = 0; n < 100 && v[0] !== 1'b0; n++) rd(5'h00, v);
    chk({v[0], wave_out_a, wave_out_b}, 16'h0000);
  endtask
  initial begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    num_errors = 0;
    check_count = 0;
    repeat (12) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    t_reset;
    t_modes;
    t_div;
    t_src;
    t_cmd;
    end_sim;
  end
endmodule // awt_timer_core_tb_top
